// file: core/aels_top.sv
// axis supervisor: amplifier enable, limit stops, home search, command output, register slave
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module aels_top #(
	parameter logic [aels_pkg::CMD_W-1:0] DECEL_STEP = aels_pkg::DECEL_STEP_DEF
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [aels_pkg::AXI_AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [aels_pkg::AXI_DW-1:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [aels_pkg::AXI_AW-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [aels_pkg::AXI_DW-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire aels_pkg::aels_pins_t PINS,
	input wire logic FOLLOW_ERR,
	output logic [aels_pkg::CMD_W-1:0] MOTOR_CMD,
	output logic AMP_EN_N,
	output logic AMP_EN_OE,
	output logic IRQ
);
	import aels_pkg::*;

	generate
		if (DECEL_STEP == '0)
		begin : g_bad_step
			$error("DECEL_STEP must be nonzero");
		end
	endgenerate

	aels_pins_t pins_s;
	aels_cfg_t cfg;
	aels_state_t state;
	logic [CMD_W-1:0] host_cmd;
	logic [POS_W-1:0] position;
	logic index_rise;
	logic index_level;
	logic homing;
	logic homed;
	logic home_hit;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_set;
	logic aw_hold;
	logic w_hold;
	logic [AXI_AW-1:0] aw_addr;
	logic [AXI_DW-1:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic wr_mapped;
	logic [AXI_DW-1:0] rd_word;
	logic rd_mapped;
	logic [7:0] wa;
	logic [7:0] ra;
	logic enable_req;
	logic off_req;
	logic home_req;
	logic dir_pos;
	logic dir_neg;
	logic lim_hit;
	logic hard_err;
	logic [CMD_W-1:0] next_cmd;
	logic [CMD_W-1:0] ramp;

	aels_sync #(
		.W(PINS_W)
	) u_sync (
		.CLK_SYS(CLK_SYS),
		.RST(RST),
		.D(PINS),
		.Q(pins_s)
	);

	always_comb
	begin
		case (cfg.index_sel)
			IDX_PLUS_HIGH: index_level = pins_s.z_plus;
			IDX_MINUS_LOW: index_level = ~pins_s.z_minus;
			default: index_level = pins_s.z_plus & ~pins_s.z_minus;
		endcase
	end

	aels_quad u_quad (
		.CLK_SYS(CLK_SYS),
		.RST(RST),
		.PHASE_A(pins_s.enc_a),
		.PHASE_B(pins_s.enc_b),
		.INDEX(index_level),
		.ZERO(home_hit),
		.POSITION(position),
		.INDEX_RISE(index_rise)
	);

	// write channel: address and data taken in either order, one write at a time
	assign S_AXI_AWREADY = ~aw_hold & ~S_AXI_BVALID;
	assign S_AXI_WREADY = ~w_hold & ~S_AXI_BVALID;
	assign do_write = aw_hold & w_hold & ~S_AXI_BVALID;
	assign wa = {aw_addr[7:2], 2'b00};

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			aw_hold <= 1'b0;
			aw_addr <= '0;
		end
		else if (S_AXI_AWVALID && S_AXI_AWREADY)
		begin
			aw_hold <= 1'b1;
			aw_addr <= S_AXI_AWADDR;
		end
		else if (do_write)
			aw_hold <= 1'b0;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			w_hold <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end
		else if (S_AXI_WVALID && S_AXI_WREADY)
		begin
			w_hold <= 1'b1;
			w_data <= S_AXI_WDATA;
			w_strb <= S_AXI_WSTRB;
		end
		else if (do_write)
			w_hold <= 1'b0;
	end

	always_comb
	begin
		case (wa)
			ADDR_CTRL, ADDR_CONFIG, ADDR_CMD, ADDR_HOME, ADDR_IRQ_STAT, ADDR_IRQ_MASK:
				wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end
		else if (do_write)
		begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		else if (S_AXI_BREADY)
			S_AXI_BVALID <= 1'b0;
	end

	function automatic logic [AXI_DW-1:0] merge(input logic [AXI_DW-1:0] old,
		input logic [AXI_DW-1:0] nw, input logic [3:0] strb);
		logic [AXI_DW-1:0] r;
		r = old;
		for (int k = 0; k < 4; k++)
			if (strb[k])
				r[k*8 +: 8] = nw[k*8 +: 8];
		return r;
	endfunction

	// commands are one-cycle strobes from writes of one, byte 0 only
	assign enable_req = do_write && wa == ADDR_CTRL && w_strb[0] && w_data[CTRL_ENABLE_BIT];
	assign off_req = do_write && wa == ADDR_CTRL && w_strb[0] && w_data[CTRL_OFF_BIT];
	assign home_req = do_write && wa == ADDR_HOME && w_strb[0] && w_data[HOME_START_BIT];

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			cfg <= CFG_RESET;
		else if (do_write && wa == ADDR_CONFIG)
		begin
			cfg <= merge(cfg, w_data, w_strb);
			cfg.rsvd <= '0;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			host_cmd <= CMD_NULL;
		else if (do_write && wa == ADDR_CMD)
			host_cmd <= CMD_W'(merge({16'h0000, host_cmd}, w_data, w_strb));
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			irq_mask <= '0;
		else if (do_write && wa == ADDR_IRQ_MASK && w_strb[0])
			irq_mask <= w_data[IRQ_W-1:0];
	end

	// limit qualification; travel direction is taken from the host command sign
	assign dir_pos = ~host_cmd[CMD_W-1] & (host_cmd != CMD_NULL);
	assign dir_neg = host_cmd[CMD_W-1];

	always_comb
	begin
		if (!cfg.limit_enable)
			lim_hit = 1'b0;
		else if (cfg.position_mode)
			lim_hit = (pins_s.lim_pos & dir_pos) | (pins_s.lim_neg & dir_neg);
		else
			lim_hit = pins_s.lim_pos | pins_s.lim_neg;
	end

	assign hard_err = pins_s.fault | FOLLOW_ERR;

	// axis state: errors win over a simultaneous enable request
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			state <= AX_OFF;
		else
		begin
			case (state)
				AX_OFF:
					if (enable_req && !hard_err && !off_req)
						state <= AX_RUN;
				AX_RUN:
					if (hard_err || off_req)
						state <= AX_OFF;
					else if (lim_hit)
						state <= (cfg.stop_mode == STOP_OFF) ? AX_OFF : AX_STOPPING;
				AX_STOPPING:
					if (hard_err || off_req || MOTOR_CMD == CMD_NULL)
						state <= AX_OFF;
				default: state <= AX_OFF;
			endcase
		end
	end

	// leaving off state needs a fresh enable request, so an error latches
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			AMP_EN_N <= 1'b1;
		else
			AMP_EN_N <= ~(next_state_run());
	end

	function automatic logic next_state_run();
		logic r;
		r = 1'b0;
		case (state)
			AX_OFF: r = enable_req && !hard_err && !off_req;
			AX_RUN: r = !(hard_err || off_req || (lim_hit && cfg.stop_mode == STOP_OFF));
			AX_STOPPING: r = !(hard_err || off_req || MOTOR_CMD == CMD_NULL);
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	assign AMP_EN_OE = ~AMP_EN_N;

	// deceleration ramp toward null, saturating so it never crosses zero
	always_comb
	begin
		if (MOTOR_CMD[CMD_W-1])
			ramp = (~MOTOR_CMD + 1'b1 <= DECEL_STEP) ? CMD_NULL : MOTOR_CMD + DECEL_STEP;
		else
			ramp = (MOTOR_CMD <= DECEL_STEP) ? CMD_NULL : MOTOR_CMD - DECEL_STEP;
	end

	always_comb
	begin
		next_cmd = CMD_NULL;
		case ((hard_err || off_req) ? AX_OFF : state)
			AX_RUN:
				if (hard_err || off_req)
					next_cmd = CMD_NULL;
				else if (lim_hit)
					next_cmd = (cfg.stop_mode == STOP_DECEL) ? MOTOR_CMD : CMD_NULL;
				else
					next_cmd = host_cmd;
			AX_STOPPING:
				next_cmd = (cfg.stop_mode == STOP_DECEL) ? ramp : CMD_NULL;
			default: next_cmd = CMD_NULL;
		endcase
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			MOTOR_CMD <= CMD_NULL;
		else
			MOTOR_CMD <= next_cmd;
	end

	// home search: only an index inside the coarse home window is true zero
	assign home_hit = homing & index_rise & pins_s.home;

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			homing <= 1'b0;
			homed <= 1'b0;
		end
		else if (home_hit)
		begin
			homing <= 1'b0;
			homed <= 1'b1;
		end
		else if (home_req)
		begin
			homing <= 1'b1;
			homed <= 1'b0;
		end
	end

	// sticky events; a set in the cycle of a clear wins
	assign irq_set[IRQ_LIMIT] = (state == AX_RUN) & lim_hit;
	assign irq_set[IRQ_FAULT] = pins_s.fault;
	assign irq_set[IRQ_FOLLOW] = FOLLOW_ERR;
	assign irq_set[IRQ_HOME] = home_hit;

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			irq_stat <= '0;
		else if (do_write && wa == ADDR_IRQ_STAT && w_strb[0])
			irq_stat <= (irq_stat & ~w_data[IRQ_W-1:0]) | irq_set;
		else
			irq_stat <= irq_stat | irq_set;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			IRQ <= 1'b0;
		else
			IRQ <= |(irq_stat & irq_mask);
	end

	// read channel: one read at a time, data registered
	assign S_AXI_ARREADY = ~S_AXI_RVALID;
	assign ra = {S_AXI_ARADDR[7:2], 2'b00};

	always_comb
	begin
		rd_mapped = 1'b1;
		rd_word = '0;
		case (ra)
			ADDR_CTRL: rd_word = '0;
			ADDR_CONFIG: rd_word = cfg;
			ADDR_CMD: rd_word = {16'h0000, host_cmd};
			ADDR_STATUS: rd_word = {16'h0000, MOTOR_CMD[CMD_W-1:CMD_W-1], 5'h00, state,
				homed, homing, FOLLOW_ERR, pins_s.fault, pins_s.home, pins_s.lim_neg,
				pins_s.lim_pos, ~AMP_EN_N};
			ADDR_POS: rd_word = position;
			ADDR_HOME: rd_word = {30'h00000000, homed, homing};
			ADDR_IRQ_STAT: rd_word = {28'h0000000, irq_stat};
			ADDR_IRQ_MASK: rd_word = {28'h0000000, irq_mask};
			default: rd_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= RESP_OKAY;
		end
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_word;
			S_AXI_RRESP <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		else if (S_AXI_RREADY)
			S_AXI_RVALID <= 1'b0;
	end
endmodule // aels_top
`default_nettype wire

// file: core/aels_pkg.sv
// package for the axis enable and limit supervisor: map, fields, types
// Notes on behaviour
// - After reset the amplifier enable output is at once high, inactive.
// - An axis enable request drives the amplifier enable output low, active.
// - Following error, an active limit or amplifier fault drops the enable.
// - A motor off command drops the amplifier enable of the axis.
// - In position mode a limit stops only motion toward that limit.
// - In other modes either active limit stops the axis, any direction.
// - Limit stop action is decelerate, stop at once, or turn off.
// - Limit reaction is switched on or off by the limit configuration.
// - Home search takes as zero only an index seen while coarse home is active.
// - Motor command is a signed 16-bit code, zero is null output.
// - Single-ended index is active high on plus or active low on minus line.
// - Position comes from quadrature phases A and B plus the index.
package aels_pkg;
	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;
	localparam int CMD_W = 16;
	localparam int POS_W = 32;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_CMD = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_POS = 8'h10;
	localparam logic [7:0] ADDR_HOME = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_OFF_BIT = 1;
	localparam int HOME_START_BIT = 0;
	localparam int IRQ_LIMIT = 0;
	localparam int IRQ_FAULT = 1;
	localparam int IRQ_FOLLOW = 2;
	localparam int IRQ_HOME = 3;
	localparam int IRQ_W = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [CMD_W-1:0] CMD_NULL = 16'h0000;
	localparam logic [CMD_W-1:0] DECEL_STEP_DEF = 16'h0010;
	typedef enum logic [1:0] {STOP_DECEL = 2'h0, STOP_NOW = 2'h1, STOP_OFF = 2'h2} aels_stop_t;
	typedef enum logic [1:0] {IDX_DIFF = 2'h0, IDX_PLUS_HIGH = 2'h1, IDX_MINUS_LOW = 2'h2} aels_idx_t;
	// gray along off -> run -> stopping; stopping -> off flips both bits
	typedef enum logic [1:0] {AX_OFF = 2'b00, AX_RUN = 2'b01, AX_STOPPING = 2'b11} aels_state_t;
	typedef struct packed {
		logic [25:0] rsvd;
		aels_idx_t index_sel;
		aels_stop_t stop_mode;
		logic position_mode;
		logic limit_enable;
	} aels_cfg_t;
	localparam aels_cfg_t CFG_RESET = '{rsvd: 26'h0, index_sel: IDX_DIFF, stop_mode: STOP_DECEL,
		position_mode: 1'b1, limit_enable: 1'b1};
	typedef struct packed {
		logic lim_pos;
		logic lim_neg;
		logic home;
		logic fault;
		logic enc_a;
		logic enc_b;
		logic z_plus;
		logic z_minus;
	} aels_pins_t;
	localparam int PINS_W = 8;
endpackage

// file: core/aels_sync.sv
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module aels_sync #(
	parameter int W = 1
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [W-1:0] D,
	output logic [W-1:0] Q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge CLK_SYS)
	begin
		s1 <= D;
		s2 <= s1;
		s3 <= s2;
	end

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge CLK_SYS)
			begin
				if (RST)
					Q[i] <= 1'b0;
				else if (s2[i] == s3[i])
					Q[i] <= s3[i];
			end
		end
	endgenerate
endmodule // aels_sync
`default_nettype wire

// file: core/aels_quad.sv
// 4x quadrature position counter with index edge detect and zeroing
`timescale 1ns/1ps
`default_nettype none
module aels_quad
	import aels_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic PHASE_A,
	input wire logic PHASE_B,
	input wire logic INDEX,
	input wire logic ZERO,
	output logic [aels_pkg::POS_W-1:0] POSITION,
	output logic INDEX_RISE
);
	logic a_q;
	logic b_q;
	logic z_q;
	logic step;
	logic up;

	// a double change is a lost step: skipped rather than guessed
	assign step = (PHASE_A ^ a_q) ^ (PHASE_B ^ b_q);
	assign up = PHASE_A ^ b_q;
	assign INDEX_RISE = INDEX & ~z_q;

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			z_q <= 1'b0;
		end
		else
		begin
			a_q <= PHASE_A;
			b_q <= PHASE_B;
			z_q <= INDEX;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST || ZERO)
			POSITION <= '0;
		else if (step)
			POSITION <= up ? POSITION + 1'b1 : POSITION - 1'b1;
	end
endmodule // aels_quad
`default_nettype wire

// file: sim/aels_props.sv
// checker for the axis supervisor: enable, following error, null command, bus answers
`timescale 1ns/1ps
`default_nettype none
module aels_props (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic FOLLOW_ERR,
	input wire logic [aels_pkg::CMD_W-1:0] MOTOR_CMD,
	input wire logic AMP_EN_N,
	input wire logic AMP_EN_OE
);
	import aels_pkg::*;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	chk_reset_off: assert property (disable iff (1'b0) RST |=> AMP_EN_N && MOTOR_CMD == CMD_NULL)
		else $error("enable active after reset");
	chk_oe_mirror: assert property (AMP_EN_OE == !AMP_EN_N)
		else $error("enable driver out of step");
	chk_error_off: assert property (FOLLOW_ERR |=> AMP_EN_N && MOTOR_CMD == CMD_NULL)
		else $error("following error left axis on");
	chk_off_null: assert property (AMP_EN_N |-> MOTOR_CMD == CMD_NULL)
		else $error("command not null while off");
	chk_enable_cause: assert property ($fell(AMP_EN_N) |-> $rose(S_AXI_BVALID))
		else $error("enable without a host write");
	chk_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
		|-> ##2 S_AXI_BVALID) else $error("write answer late");
	chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	chk_write_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken while answer pending");
	cover property ($fell(AMP_EN_N));
	cover property (FOLLOW_ERR && !AMP_EN_N);
	cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
endmodule // aels_props
bind aels_top aels_props i_aels_props (.*);
`default_nettype wire

// file: sim/aels_field.sv
// field side model: limit, home and fault switches plus a quadrature encoder
`timescale 1ns/1ps
`default_nettype none
module aels_field (
	input wire logic CLK_SYS,
	output wire aels_pkg::aels_pins_t PINS
);
	import aels_pkg::*;
	logic [4:0] sw = 5'h00;
	logic [1:0] s = 2'h0;
	logic zm = 1'b0;
	// minus index line alone, so the single-ended index modes can be told apart
	task automatic zneg(input logic v);
		@(posedge CLK_SYS);
		zm <= v;
		repeat (8) @(posedge CLK_SYS);
	endtask
	// held long enough to pass the input synchroniser
	task automatic set(input logic [4:0] v);
		@(posedge CLK_SYS);
		sw <= v;
		repeat (8) @(posedge CLK_SYS);
	endtask
	// one phase edge; up walks the gray code backwards so A leads
	task automatic step(input logic up);
		@(posedge CLK_SYS);
		s <= up ? s - 2'h1 : s + 2'h1;
		repeat (8) @(posedge CLK_SYS);
	endtask
	assign PINS = {sw[4:1], s[1], s[1] ^ s[0], sw[0], !sw[0] ^ zm};
endmodule // aels_field
`default_nettype wire

// file: sim/test_aels_top.sv
// self-checking bench for the axis supervisor
`timescale 1ns/1ps
`default_nettype none
module test_aels_top;
	import aels_pkg::*;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [3:0] s;
		logic [31:0] e; logic [1:0] r;} aels_row_t;
	// byte lanes: only lane 1 of the command lands, a control write without lane 0 is void
	localparam aels_row_t ROWS [7] = '{
		'{1'h0, ADDR_CONFIG, 32'h0, 4'hF, 32'h3, RESP_OKAY},
		'{1'h1, ADDR_IRQ_MASK, 32'hFFFFFFFF, 4'hF, 32'hF, RESP_OKAY},
		'{1'h1, ADDR_CONFIG, 32'hFFFFFFFF, 4'hF, 32'h3F, RESP_OKAY},
		'{1'h1, ADDR_CONFIG, 32'hFFFFFF03, 4'h1, 32'h3, RESP_OKAY},
		'{1'h1, ADDR_CMD, 32'h000001AB, 4'h2, 32'h100, RESP_OKAY},
		'{1'h1, 8'h20, 32'h1, 4'hF, 32'h0, RESP_SLVERR},
		'{1'h1, ADDR_CTRL, 32'h1, 4'hE, 32'h0, RESP_OKAY}};
	logic clk_sys, rst, awvalid, wvalid, bready, arvalid, rready, follow;
	logic awready, wready, bvalid, arready, rvalid, amp_en_n, amp_en_oe, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d, p;
	logic [1:0] bresp, rresp, r;
	logic [3:0] wstrb;
	logic [15:0] motor_cmd;
	aels_pins_t pins;
	int mismatches = 0;
	int tests_run = 0;
	aels_top i_aels_top (.CLK_SYS(clk_sys), .RST(rst), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.PINS(pins), .FOLLOW_ERR(follow), .MOTOR_CMD(motor_cmd), .AMP_EN_N(amp_en_n),
		.AMP_EN_OE(amp_en_oe), .IRQ(irq));
	aels_field i_aels_field (.CLK_SYS(clk_sys), .PINS(pins));
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	// address and data released separately, each when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw || w || !bvalid)
		begin
			@(posedge clk_sys);
			if (awready)
				aw = 1'b0;
			if (wready)
				w = 1'b0;
			awvalid <= aw;
			wvalid <= w;
		end
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_sys); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid)
			@(posedge clk_sys);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task automatic en;
		wr(ADDR_CTRL, 32'h1, r);
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#100us;
		mismatches++;
		test_done;
	end
	initial
	begin
		{rst, awvalid, wvalid, bready, arvalid, rready, follow} = 7'h40;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		cyc(6);
		rst <= 1'b0;
		cmp(amp_en_n, 32'h1);
		cmp(motor_cmd, 32'h0);
		foreach (ROWS[i])
		begin
			if (ROWS[i].w)
			begin
				wstrb <= ROWS[i].s;
				wr(ROWS[i].a, ROWS[i].d, r);
				cmp(r, ROWS[i].r);
			end
			rd(ROWS[i].a, d, r);
			cmp(d, ROWS[i].e);
			cmp(r, ROWS[i].r);
		end
		cmp(amp_en_n, 32'h1);
		$display("end register rows");
		wstrb <= 4'hF;
		en;
		cmp(amp_en_n, 32'h0);
		cmp(amp_en_oe, 32'h1);
		cyc(2);
		cmp(motor_cmd, 32'h100);
		wr(ADDR_CMD, 32'hFF00, r);
		cyc(2);
		cmp(motor_cmd, 32'hFF00);
		wr(ADDR_CTRL, 32'h2, r);
		cmp(amp_en_n, 32'h1);
		cmp(motor_cmd, 32'h0);
		$display("end enable and off");
		// moving negative: positive limit must be ignored
		en;
		i_aels_field.set(5'h10);
		cmp(amp_en_n, 32'h0);
		i_aels_field.set(5'h08);
		cyc(30);
		cmp(amp_en_n, 32'h1);
		i_aels_field.set(5'h00);
		for (int m = 0; m < 3; m++)
		begin
			wr(ADDR_CONFIG, 32'h1 | (m << 2), r);
			en;
			i_aels_field.set(5'h10);
			cmp(amp_en_n, m == 0 ? 32'h0 : 32'h1);
			cyc(30);
			cmp(amp_en_n, 32'h1);
			i_aels_field.set(5'h00);
		end
		wr(ADDR_CONFIG, 32'h2, r);
		en;
		i_aels_field.set(5'h08);
		cmp(amp_en_n, 32'h0);
		i_aels_field.set(5'h00);
		$display("end limits");
		rd(ADDR_POS, p, r);
		repeat (5) i_aels_field.step(1'b1);
		repeat (2) i_aels_field.step(1'b0);
		rd(ADDR_POS, d, r);
		cmp(d, p + 32'h3);
		wr(ADDR_CONFIG, 32'h22, r);
		wr(ADDR_HOME, 32'h1, r);
		i_aels_field.set(5'h01);
		i_aels_field.set(5'h00);
		rd(ADDR_HOME, d, r);
		cmp(d, 32'h1);
		i_aels_field.set(5'h04);
		i_aels_field.set(5'h05);
		i_aels_field.set(5'h04);
		rd(ADDR_HOME, d, r);
		cmp(d, 32'h2);
		rd(ADDR_POS, d, r);
		cmp(d, 32'h0);
		wr(ADDR_CONFIG, 32'h12, r);
		wr(ADDR_HOME, 32'h1, r);
		i_aels_field.zneg(1'b1);
		rd(ADDR_HOME, d, r);
		cmp(d, 32'h1);
		i_aels_field.set(5'h05);
		rd(ADDR_HOME, d, r);
		cmp(d, 32'h2);
		i_aels_field.zneg(1'b0);
		i_aels_field.set(5'h00);
		$display("end encoder and home");
		wr(ADDR_IRQ_STAT, 32'hF, r);
		cyc(2);
		cmp(irq, 32'h0);
		i_aels_field.set(5'h02);
		cmp(amp_en_n, 32'h1);
		cmp(irq, 32'h1);
		i_aels_field.set(5'h00);
		cmp(amp_en_n, 32'h1);
		wr(ADDR_IRQ_STAT, 32'hF, r);
		cyc(2);
		cmp(irq, 32'h0);
		en;
		cmp(amp_en_n, 32'h0);
		follow <= 1'b1;
		cyc(2);
		cmp(amp_en_n, 32'h1);
		// an event present in the cycle of the clear must survive it
		wr(ADDR_IRQ_STAT, 32'hF, r);
		rd(ADDR_IRQ_STAT, d, r);
		cmp(d, 32'h4);
		wr(ADDR_IRQ_MASK, 32'h0, r);
		cyc(2);
		cmp(irq, 32'h0);
		follow <= 1'b0;
		$display("end faults");
		en;
		cmp(amp_en_n, 32'h0);
		rst <= 1'b1;
		cyc(2);
		cmp(amp_en_n, 32'h1);
		cmp(motor_cmd, 32'h0);
		cyc(4);
		rst <= 1'b0;
		rd(ADDR_CONFIG, d, r);
		cmp(d, 32'h3);
		$display("end mid-run reset");
		test_done;
	end
endmodule // test_aels_top
`default_nettype wire
